// ### verilog/vir_defs.svh
/*
 * constant names for the vectored interrupt router: counts, field
 * positions, register offsets and response codes.
 * assumes it is included by its bare name, before the package.
 */
`ifndef VIR_DEFS_SVH
`define VIR_DEFS_SVH

`define VIR_N_SRC 56
`define VIR_PRIO_W 4
`define VIR_IDX_W 6
`define VIR_ADDR_W 12
`define VIR_CFG_W 5

`define VIR_A_RAW_LO 12'h000
`define VIR_A_RAW_HI 12'h004
`define VIR_A_POL_LO 12'h008
`define VIR_A_POL_HI 12'h00c
`define VIR_A_SWR_LO 12'h010
`define VIR_A_SWR_HI 12'h014
`define VIR_A_THRESH 12'h018
`define VIR_A_VEC_FAST 12'h01c
`define VIR_A_VEC_NORM 12'h020
`define VIR_A_INT_STAT 12'h024
`define VIR_A_INT_MASK 12'h028
`define VIR_CFG_PAGE 4'h1

`define VIR_CFG_TGT_BIT 8
`define VIR_THR_FAST_LSB 0
`define VIR_THR_NORM_LSB 8
`define VIR_VEC_PRIO_LSB 8
`define VIR_VEC_VALID_BIT 31
`define VIR_TGT_FAST 1'b0
`define VIR_TGT_NORM 1'b1
`define VIR_PRIO_MASKED 4'h0

`define VIR_RESP_OKAY 2'b00
`define VIR_RESP_SLVERR 2'b10

`endif

// ### verilog/vir_pkg.sv
/*
 * types shared by the vectored interrupt router files.
 * assumes vir_defs.svh is on the include path.
 */
`include "vir_defs.svh"

package vir_pkg;
    typedef logic [`VIR_PRIO_W-1:0] vir_prio_t;
    typedef logic [`VIR_IDX_W-1:0] vir_idx_t;
    typedef logic [`VIR_CFG_W-1:0] vir_cfg_t;
    typedef enum logic [1:0] {VIR_RD_IDLE, VIR_RD_WAIT, VIR_RD_RESP} vir_rd_e;
endpackage

// ### verilog/vir_cfg_mem.sv
/*
 * per-source configuration store: one write port, two registered read ports.
 * assumes a single clock; all entries clear under synchronous reset.
 */
`timescale 1ns/100ps

module vir_cfg_mem
    import vir_pkg::*;
#(
    parameter int DEPTH = `VIR_N_SRC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_en,
    input wire vir_idx_t wr_addr,
    input wire vir_cfg_t wr_data,
    input wire vir_idx_t rd_a_addr,
    output vir_cfg_t rd_a_data,
    input wire vir_idx_t rd_b_addr,
    output vir_cfg_t rd_b_data
);
    vir_cfg_t mem_r [DEPTH];

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            rd_a_data <= '0;
            rd_b_data <= '0;
        end else begin
            if (wr_en && (int'(wr_addr) < DEPTH)) begin
                mem_r[wr_addr] <= wr_data;
            end
            rd_a_data <= (int'(rd_a_addr) < DEPTH) ? mem_r[rd_a_addr] : '0;
            rd_b_data <= (int'(rd_b_addr) < DEPTH) ? mem_r[rd_b_addr] : '0;
        end
    end
endmodule

// ### verilog/vir_top.sv
/*
 * vectored interrupt router: request inputs, polarity, software requests,
 * per-source priority and target, per-target threshold, vectors, axi4-lite.
 * assumes request inputs are asynchronous; the bus master is on mclk.
 */
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
// What this block does
// [R1] 56 level inputs with software polarity
// [R2] per-input software request register
// [R3] raw request state readable before masking
// [R4] per-input priority, fifteen levels plus disabled
// [R5] target 0 fast, target 1 normal
// [R6] per-target threshold gates each request
// [R7] priority zero never interrupts
// [R8] 1 lowest, 15 highest urgency
// [R9] vector names the winning request
// [R10] raised threshold lets higher requests nest
// [R11] all logic on the controller branch clock
// [R12] equal priority: lowest input index wins
// [R13] target output held while request qualifies
`timescale 1ns/100ps

module vir_top
    import vir_pkg::*;
#(
    parameter int N_SRC = `VIR_N_SRC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [N_SRC-1:0] irq_req_in,
    input wire logic [`VIR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`VIR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic fast_interrupt_request,
    output logic normal_interrupt_request,
    output logic [31:0] fast_vector,
    output logic [31:0] normal_vector,
    output logic int_out
);
    function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] mkvec(logic v, vir_prio_t p, vir_idx_t i);
        logic [31:0] r;
        r = '0;
        r[`VIR_VEC_VALID_BIT] = v;
        r[`VIR_VEC_PRIO_LSB +: `VIR_PRIO_W] = p;
        r[`VIR_IDX_W-1:0] = i;
        return r;
    endfunction
    function automatic logic cfg_hit(logic [`VIR_ADDR_W-1:0] a);
        return a[`VIR_ADDR_W-1:8] == `VIR_CFG_PAGE && int'(a[`VIR_IDX_W+1:2]) < N_SRC
            && a[1:0] == 2'b00;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state and next values
    logic [N_SRC-1:0] sync1_r, sync2_r;
    logic [63:0] pol_r, pol_nxt, swr_r, swr_nxt, raw;
    vir_rd_e rd_st_r, rd_st_nxt;
    logic [`VIR_ADDR_W-1:0] ar_addr_r, ar_addr_nxt, aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt, rdata_nxt, thr_r, thr_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic awready_nxt, wready_nxt, arready_nxt, bvalid_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
    logic int_nxt, fast_nxt, norm_nxt;
    logic [31:0] vecf_nxt, vecn_nxt;
    vir_idx_t scan_idx_r, scan_idx_nxt, scan_cur_r, scan_cur_nxt;
    logic scan_ok_r, scan_ok_nxt;
    logic [1:0] bv_r, bv_nxt;
    vir_prio_t bp_r [2];
    vir_prio_t bp_nxt [2];
    vir_idx_t bi_r [2];
    vir_idx_t bi_nxt [2];
    logic mem_we, exec, hit, tgt;
    vir_cfg_t mem_wd, cfg_a, cfg_b;
    vir_prio_t p, thr;

    vir_cfg_mem #(
        .DEPTH(N_SRC)
    ) u_cfg (
        .mclk(mclk),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(aw_addr_r[`VIR_IDX_W+1:2]),
        .wr_data(mem_wd),
        .rd_a_addr(s_axi_araddr[`VIR_IDX_W+1:2]),
        .rd_a_data(cfg_a),
        .rd_b_addr(scan_idx_r),
        .rd_b_data(cfg_b)
    );
    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        raw = '0;
        raw[N_SRC-1:0] = (sync2_r ^ pol_r[N_SRC-1:0]) | swr_r[N_SRC-1:0]; // [R1] [R2]
        pol_nxt = pol_r;
        swr_nxt = swr_r;
        thr_nxt = thr_r;
        mask_nxt = mask_r;
        ar_addr_nxt = ar_addr_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        arready_nxt = s_axi_arready;
        rd_st_nxt = rd_st_r;
        mem_we = 1'b0;
        mem_wd = {w_data_r[`VIR_CFG_TGT_BIT], w_data_r[`VIR_PRIO_W-1:0]};
        vecf_nxt = fast_vector;
        vecn_nxt = normal_vector;
        fast_nxt = fast_interrupt_request;
        norm_nxt = normal_interrupt_request;
        bv_nxt = bv_r;
        bp_nxt = bp_r;
        bi_nxt = bi_r;
        ev = 2'b00;
        // write channel
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        exec = aw_have_r && w_have_r && !s_axi_bvalid;
        if (exec) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `VIR_RESP_OKAY;
            case (aw_addr_r)
                `VIR_A_POL_LO: pol_nxt[31:0] = wmerge(pol_r[31:0], w_data_r, w_strb_r); // [R1]
                `VIR_A_POL_HI: pol_nxt[63:32] = wmerge(pol_r[63:32], w_data_r, w_strb_r);
                `VIR_A_SWR_LO: swr_nxt[31:0] = wmerge(swr_r[31:0], w_data_r, w_strb_r); // [R2]
                `VIR_A_SWR_HI: swr_nxt[63:32] = wmerge(swr_r[63:32], w_data_r, w_strb_r);
                `VIR_A_THRESH: thr_nxt = wmerge(thr_r, w_data_r, w_strb_r); // [R6] [R10]
                `VIR_A_INT_MASK: mask_nxt = w_strb_r[0] ? w_data_r[1:0] : mask_r;
                `VIR_A_INT_STAT, `VIR_A_RAW_LO, `VIR_A_RAW_HI,
                `VIR_A_VEC_FAST, `VIR_A_VEC_NORM: ;
                default: begin
                    if (cfg_hit(aw_addr_r)) begin
                        mem_we = w_strb_r[0]; // [R4] [R5]
                    end else begin
                        bresp_nxt = `VIR_RESP_SLVERR;
                    end
                end
            endcase
        end
        pol_nxt[63:N_SRC] = '0;
        swr_nxt[63:N_SRC] = '0;
        awready_nxt = !aw_have_nxt;
        wready_nxt = !w_have_nxt;
        // read channel
        case (rd_st_r)
            VIR_RD_IDLE: begin
                arready_nxt = 1'b1;
                if (s_axi_arvalid && s_axi_arready) begin
                    ar_addr_nxt = s_axi_araddr;
                    arready_nxt = 1'b0;
                    rd_st_nxt = VIR_RD_WAIT;
                end
            end
            VIR_RD_WAIT: begin
                rvalid_nxt = 1'b1;
                rresp_nxt = `VIR_RESP_OKAY;
                case (ar_addr_r)
                    `VIR_A_RAW_LO: rdata_nxt = raw[31:0]; // [R3]
                    `VIR_A_RAW_HI: rdata_nxt = raw[63:32];
                    `VIR_A_POL_LO: rdata_nxt = pol_r[31:0];
                    `VIR_A_POL_HI: rdata_nxt = pol_r[63:32];
                    `VIR_A_SWR_LO: rdata_nxt = swr_r[31:0];
                    `VIR_A_SWR_HI: rdata_nxt = swr_r[63:32];
                    `VIR_A_THRESH: rdata_nxt = thr_r;
                    `VIR_A_VEC_FAST: rdata_nxt = fast_vector; // [R9]
                    `VIR_A_VEC_NORM: rdata_nxt = normal_vector;
                    `VIR_A_INT_STAT: rdata_nxt = {30'h0, stat_r};
                    `VIR_A_INT_MASK: rdata_nxt = {30'h0, mask_r};
                    default: begin
                        rdata_nxt = '0;
                        if (cfg_hit(ar_addr_r)) begin
                            rdata_nxt[`VIR_PRIO_W-1:0] = cfg_a[`VIR_PRIO_W-1:0];
                            rdata_nxt[`VIR_CFG_TGT_BIT] = cfg_a[`VIR_PRIO_W];
                        end else begin
                            rresp_nxt = `VIR_RESP_SLVERR;
                        end
                    end
                endcase
                rd_st_nxt = VIR_RD_RESP;
            end
            VIR_RD_RESP: begin
                if (s_axi_rready) begin
                    rvalid_nxt = 1'b0;
                    arready_nxt = 1'b1;
                    rd_st_nxt = VIR_RD_IDLE;
                end
            end
            default: rd_st_nxt = VIR_RD_IDLE;
        endcase
        // priority scan, one source per cycle
        scan_idx_nxt = (int'(scan_idx_r) == N_SRC - 1) ? '0 : scan_idx_r + 1'b1;
        scan_cur_nxt = scan_idx_r;
        scan_ok_nxt = 1'b1;
        p = cfg_b[`VIR_PRIO_W-1:0];
        tgt = cfg_b[`VIR_PRIO_W]; // [R5]
        thr = (tgt == `VIR_TGT_NORM) ? thr_r[`VIR_THR_NORM_LSB +: `VIR_PRIO_W]
                                     : thr_r[`VIR_THR_FAST_LSB +: `VIR_PRIO_W];
        hit = scan_ok_r && raw[scan_cur_r] && (p != `VIR_PRIO_MASKED) && (p > thr); // [R6] [R7]
        if (hit && (!bv_r[tgt] || p > bp_r[tgt])) begin // [R8] [R12]
            bv_nxt[tgt] = 1'b1;
            bp_nxt[tgt] = p;
            bi_nxt[tgt] = scan_cur_r;
        end
        if (scan_ok_r && int'(scan_cur_r) == N_SRC - 1) begin
            fast_nxt = bv_nxt[`VIR_TGT_FAST]; // [R13]
            norm_nxt = bv_nxt[`VIR_TGT_NORM];
            vecf_nxt = mkvec(bv_nxt[0], bp_nxt[0], bi_nxt[0]); // [R9]
            vecn_nxt = mkvec(bv_nxt[1], bp_nxt[1], bi_nxt[1]);
            ev = {norm_nxt & !normal_interrupt_request, fast_nxt & !fast_interrupt_request};
            bv_nxt = 2'b00;
        end
        // sticky status: a new event beats a same-cycle clear
        stat_nxt = stat_r;
        if (exec && aw_addr_r == `VIR_A_INT_STAT && w_strb_r[0]) begin
            stat_nxt = stat_r & ~w_data_r[1:0];
        end
        stat_nxt = stat_nxt | ev;
        int_nxt = |(stat_nxt & mask_nxt);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk) begin // [R11]
        if (rst) begin
            pol_r <= '0;
            swr_r <= '0;
            thr_r <= '0;
            mask_r <= '0;
            stat_r <= '0;
            ar_addr_r <= '0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            rd_st_r <= VIR_RD_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VIR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `VIR_RESP_OKAY;
            s_axi_rdata <= '0;
            scan_idx_r <= '0;
            scan_cur_r <= '0;
            scan_ok_r <= 1'b0;
            bv_r <= 2'b00;
            bp_r <= '{default: '0};
            bi_r <= '{default: '0};
            fast_interrupt_request <= 1'b0;
            normal_interrupt_request <= 1'b0;
            fast_vector <= '0;
            normal_vector <= '0;
            int_out <= 1'b0;
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            pol_r <= pol_nxt;
            swr_r <= swr_nxt;
            thr_r <= thr_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            ar_addr_r <= ar_addr_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            rd_st_r <= rd_st_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            scan_idx_r <= scan_idx_nxt;
            scan_cur_r <= scan_cur_nxt;
            scan_ok_r <= scan_ok_nxt;
            bv_r <= bv_nxt;
            bp_r <= bp_nxt;
            bi_r <= bi_nxt;
            fast_interrupt_request <= fast_nxt;
            normal_interrupt_request <= norm_nxt;
            fast_vector <= vecf_nxt;
            normal_vector <= vecn_nxt;
            int_out <= int_nxt;
            sync1_r <= irq_req_in;
            sync2_r <= sync1_r;
        end
    end
endmodule

// ### verification/vir_checker.sv
/*
 * port checker for vir_top: bus answers, vector words, reset state.
 * assumes it is bound to vir_top and sees only its ports.
 */
`timescale 1ns/100ps
`include "vir_defs.svh"

module vir_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fast_interrupt_request,
    input wire logic normal_interrupt_request,
    input wire logic [31:0] fast_vector,
    input wire logic [31:0] normal_vector,
    input wire logic int_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////
    property p_wr_ans;
        !s_axi_bvalid && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_wr_hold;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("bvalid stuck");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rvalid stuck");
    property p_fast_vec;
        fast_interrupt_request |-> fast_vector[31] && fast_vector[11:8] != 4'h0;
    endproperty
    a_fast_vec: assert property (p_fast_vec) else $error("fast vector bad");
    property p_norm_vec;
        normal_interrupt_request |-> normal_vector[31] && normal_vector[11:8] != 4'h0;
    endproperty
    a_norm_vec: assert property (p_norm_vec) else $error("normal vector bad");
    property p_fast_idx;
        fast_vector[31] |-> fast_vector[5:0] < `VIR_N_SRC;
    endproperty
    a_fast_idx: assert property (p_fast_idx) else $error("fast index range");
    property p_norm_idx;
        normal_vector[31] |-> normal_vector[5:0] < `VIR_N_SRC;
    endproperty
    a_norm_idx: assert property (p_norm_idx) else $error("normal index range");
    property p_rst_quiet;
        disable iff (1'b0)
        rst |=> !fast_interrupt_request && !normal_interrupt_request && !int_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output during reset");
////////////////////////////////////////////////////////////
    c_fast: cover property ($rose(fast_interrupt_request));
    c_norm: cover property ($rose(normal_interrupt_request));
    c_int: cover property ($rose(int_out));
endmodule

bind vir_top vir_checker chk_u (.*);

// ### verification/vir_core_model.sv
/*
 * processor core stand-in: latches each vector as its request rises.
 * assumes the router outputs change on mclk.
 */
`timescale 1ns/100ps

module vir_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic fast_interrupt_request,
    input wire logic normal_interrupt_request,
    input wire logic [31:0] fast_vector,
    input wire logic [31:0] normal_vector,
    output logic [31:0] fast_seen,
    output logic [31:0] normal_seen
);
    logic fast_r;
    logic norm_r;
////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        fast_r <= rst ? 1'h0 : fast_interrupt_request;
        norm_r <= rst ? 1'h0 : normal_interrupt_request;
        if (rst)
            fast_seen <= 32'h0;
        else if (fast_interrupt_request && !fast_r)
            fast_seen <= fast_vector;
        if (rst)
            normal_seen <= 32'h0;
        else if (normal_interrupt_request && !norm_r)
            normal_seen <= normal_vector;
    end
endmodule

// ### verification/vir_tb.sv
/*
 * self-checking bench for vir_top with a core stand-in.
 * assumes checker and core model are compiled first.
 */
`timescale 1ns/100ps
`include "vir_defs.svh"

module tb;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [55:0] irq_req_in = '0;
    logic [11:0] s_axi_awaddr = '0;
    logic [11:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
    logic [31:0] s_axi_rdata, fast_vector, normal_vector, fast_seen, normal_seen, rd_q;
    logic fast_interrupt_request, normal_interrupt_request, int_out;
    int mismatches = 0;
    int checked = 0;

    always #50 mclk = ~mclk;
    vir_top dut_u (.*);
    vir_core_model core_u (.*);
////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'h1) @(posedge mclk);
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_q, e);
        chk({30'h0, resp_q}, {30'h0, `VIR_RESP_OKAY});
    endtask
    task automatic sweep;
        repeat (130) @(posedge mclk);
    endtask
    task automatic flag(input logic f, input logic e);
        chk({31'h0, f}, {31'h0, e});
    endtask
////////////////////////////////////////////////////////////
    task automatic t_polarity;
        rdchk(`VIR_A_RAW_LO, 32'h0);
        irq_req_in <= 56'h8;
        sweep;
        rdchk(`VIR_A_RAW_LO, 32'h8);
        wr(`VIR_A_POL_LO, 32'h8);
        sweep;
        rdchk(`VIR_A_RAW_LO, 32'h0);
    endtask
    task automatic t_swreq;
        wr(`VIR_A_SWR_HI, 32'h100);
        wr(`VIR_A_SWR_LO, 32'h0010_0220);
        sweep;
        rdchk(`VIR_A_RAW_HI, 32'h100);
        rdchk(`VIR_A_RAW_LO, 32'h0010_0220);
        flag(fast_interrupt_request, 1'h0);
    endtask
    task automatic t_prio;
        int lost;
        lost = 0;
        wr(12'h114, 32'h3);
        sweep;
        flag(fast_interrupt_request, 1'h1);
        rdchk(`VIR_A_VEC_FAST, 32'h8000_0305);
        chk(fast_seen, 32'h8000_0305);
        wr(12'h124, 32'h3);
        repeat (130) @(posedge mclk) if (fast_interrupt_request !== 1'h1) lost++;
        chk(lost, 32'h0);
        chk(fast_vector, 32'h8000_0305);
        wr(12'h124, 32'h7);
        sweep;
        chk(fast_vector, 32'h8000_0709);
        flag(normal_interrupt_request, 1'h0);
    endtask
    task automatic t_thresh;
        wr(`VIR_A_THRESH, 32'h407);
        wr(12'h150, 32'h104);
        sweep;
        flag(fast_interrupt_request, 1'h0);
        flag(normal_interrupt_request, 1'h0);
        wr(`VIR_A_THRESH, 32'h306);
        sweep;
        chk(fast_vector, 32'h8000_0709);
        flag(normal_interrupt_request, 1'h1);
        chk(normal_vector, 32'h8000_0414);
        chk(normal_seen, 32'h8000_0414);
        wr(12'h114, 32'h0);
        wr(12'h124, 32'h0);
        sweep;
        flag(fast_interrupt_request, 1'h0);
        flag(normal_interrupt_request, 1'h1);
    endtask
    task automatic t_irq;
        rdchk(`VIR_A_INT_STAT, 32'h3);
        flag(int_out, 1'h0);
        wr(`VIR_A_INT_MASK, 32'h2);
        rdchk(`VIR_A_INT_MASK, 32'h2);
        flag(int_out, 1'h1);
        wr(`VIR_A_INT_STAT, 32'h3);
        rdchk(`VIR_A_INT_STAT, 32'h0);
        flag(int_out, 1'h0);
        wr(`VIR_A_INT_MASK, 32'h0);
    endtask
    task automatic t_bus;
        rd(12'h0fc);
        chk({30'h0, resp_q}, {30'h0, `VIR_RESP_SLVERR});
        wr(12'h0fc, 32'h1);
        chk({30'h0, resp_q}, {30'h0, `VIR_RESP_SLVERR});
        wr(`VIR_A_RAW_LO, 32'hffff_ffff);
        chk({30'h0, resp_q}, {30'h0, `VIR_RESP_OKAY});
        rdchk(`VIR_A_RAW_LO, 32'h0010_0220);
    endtask
////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        t_polarity;
        t_swreq;
        t_prio;
        t_thresh;
        t_irq;
        t_bus;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        complete_run;
    end
endmodule
